// File: lti_int_line.sv
// Host side interrupt line model: open-drain wire with pull-up
`timescale 1ns/1ps
module lti_int_line
(
    input  wire logic i_oe,
    input  wire logic i_out,
    output logic      o_pin
);
    // Released line floats to the pull-up, never to a stale value
    assign o_pin = i_oe ? i_out : 1'b1;
endmodule

// File: lti_monitor.sv
// Bus handshake and pin checks on the threshold interrupt block ports
`timescale 1ns/1ps
module lti_monitor
(
    input wire logic                         i_clk,
    input wire logic                         i_reset,
    input wire logic                         i_conv_done,
    input wire logic [lti_pkg::RESULT_W-1:0] i_result,
    input wire logic                         o_int_oe,
    input wire logic                         o_int_out,
    input wire logic [31:0]                  i_awaddr,
    input wire logic                         i_awvalid,
    input wire logic                         o_awready,
    input wire logic [31:0]                  i_wdata,
    input wire logic [3:0]                   i_wstrb,
    input wire logic                         i_wvalid,
    input wire logic                         o_wready,
    input wire logic [1:0]                   o_bresp,
    input wire logic                         o_bvalid,
    input wire logic                         i_bready,
    input wire logic [31:0]                  i_araddr,
    input wire logic                         i_arvalid,
    input wire logic                         o_arready,
    input wire logic [31:0]                  o_rdata,
    input wire logic [1:0]                   o_rresp,
    input wire logic                         o_rvalid,
    input wire logic                         i_rready
);
    import lti_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_taken;
        i_arvalid && o_arready;
    endsequence
    wr_resp_time_a: assert property (wr_taken |-> ##2 o_bvalid)
        else $error("write response not two cycles after address and data");
    wr_ro_err_a: assert property ((wr_taken ##0 i_awaddr == AXI_OFF_STATUS) |-> ##2 o_bresp == RESP_SLVERR)
        else $error("status write not refused");
    rd_resp_time_a: assert property (rd_taken |=> o_rvalid)
        else $error("read data not one cycle after address");
    rd_unmapped_a: assert property ((rd_taken ##0 i_araddr == 32'h0000_0014) |=> o_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    b_release_a: assert property ($fell(o_bvalid) |-> $past(i_bready))
        else $error("write response dropped before taken");
    r_release_a: assert property ($fell(o_rvalid) |-> $past(i_rready))
        else $error("read data dropped before taken");
    wr_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while response pending");
    rd_busy_a: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted while data pending");
    pin_drain_a: assert property (!o_int_out)
        else $error("interrupt pin driven high");
    pin_quiet_a: assert property ($changed(o_int_oe) |-> $past(i_conv_done, 2)
        || $past(i_arvalid && o_arready, 2) || ($past(o_bvalid) && !$past(o_bvalid, 2)))
        else $error("interrupt pin moved without a conversion or register access");
endmodule
bind lti_top lti_monitor u_mon (.i_clk, .i_reset, .i_conv_done, .i_result, .o_int_oe, .o_int_out, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);

// File: lti_pkg.sv
// Constants and types for the light threshold interrupt logic
package lti_pkg;
    localparam int          RESULT_W       = 16;
    localparam int          FAULT_CNT_W    = 2;
    localparam int          EVT_CNT_W      = 3;
    localparam int          CFG_W          = 16;
    localparam int          CFG_LATCH_BIT  = 4;
    localparam int          CFG_POL_BIT    = 3;
    localparam int          CFG_FC_LSB     = 0;
    localparam int          CFG_MODE_LSB   = 9;
    localparam int          LOW_EXP_TOP_HI = 15;
    localparam int          LOW_EXP_TOP_LO = 14;
    localparam logic [1:0]  MODE_SHUTDOWN  = 2'h0;
    localparam logic [1:0]  EXP_TOP_EOC    = 2'h3;
    localparam logic [31:0] AXI_OFF_CFG    = 32'h0000_0000;
    localparam logic [31:0] AXI_OFF_HIGH   = 32'h0000_0004;
    localparam logic [31:0] AXI_OFF_LOW    = 32'h0000_0008;
    localparam logic [31:0] AXI_OFF_STATUS = 32'h0000_000c;
    localparam logic [31:0] AXI_OFF_ALERT  = 32'h0000_0010;
    localparam logic [CFG_W-1:0] CFG_RESET    = 16'h0000;
    localparam logic [RESULT_W-1:0] HIGH_RESET = 16'hbfff;
    localparam logic [RESULT_W-1:0] LOW_RESET  = 16'h0000;
    localparam int          STAT_FH_BIT    = 2;
    localparam int          STAT_FL_BIT    = 1;
    localparam int          STAT_CRF_BIT   = 0;
    localparam int          STAT_INT_BIT   = 3;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    typedef enum logic [1:0] {
        LTI_W_IDLE = 2'b01,
        LTI_W_RESP = 2'b10
    } lti_wr_state_t;
endpackage

// File: lti_tb_top.sv
// Self-checking bench for the light threshold interrupt block
`timescale 1ns/1ps
module lti_tb_top;
    import lti_pkg::*;
    logic        i_clk, i_reset, i_conv_done, o_int_oe, o_int_out, int_pin;
    logic [15:0] i_result;
    logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, rdat;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, last_resp;
    logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic        i_arvalid, o_arready, o_rvalid, i_rready;
    int          n_errors, n_compared, cycles;

    lti_top DUT (.i_clk, .i_reset, .i_conv_done, .i_result, .o_int_oe, .o_int_out, .i_awaddr, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
    lti_int_line u_line (.i_oe(o_int_oe), .i_out(o_int_out), .o_pin(int_pin));

    always #50 i_clk = ~i_clk;

    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Generous ceiling: whole run needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Each channel released at the edge where it is taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_awaddr  <= a;
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (o_awready)
                i_awvalid <= 1'b0;
            if (o_wready)
                i_wvalid <= 1'b0;
            if (o_bvalid)
                break;
        end
        last_resp = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        forever
        begin
            @(posedge i_clk);
            if (o_arready)
                i_arvalid <= 1'b0;
            if (o_rvalid)
                break;
        end
        d = o_rdata;
        last_resp = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic conv(input logic [15:0] r);
        i_result    <= r;
        i_conv_done <= 1'b1;
        @(posedge i_clk);
        i_conv_done <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask

    // Status word is {int, flag high, flag low, ready}; pin seen through the pull-up
    task automatic st(input string nm, input logic [3:0] e, input logic p);
        logic [31:0] d;
        rd(AXI_OFF_STATUS, d);
        chk(nm, {28'h0, e}, d);
        chk({nm, " pin"}, {31'h0, p}, {31'h0, int_pin});
    endtask

    task automatic t_reset();
        rd(AXI_OFF_CFG, rdat);
        chk("cfg", {16'h0, CFG_RESET}, rdat);
        rd(AXI_OFF_HIGH, rdat);
        chk("high", {16'h0, HIGH_RESET}, rdat);
        rd(AXI_OFF_LOW, rdat);
        chk("low", {16'h0, LOW_RESET}, rdat);
        st("idle", 4'h0, 1'b1);
        rd(32'h0000_0014, rdat);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
        wr(AXI_OFF_STATUS, 32'h0000_000f);
        chk("ro write", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
        $display("t_reset done");
    endtask

    task automatic t_latched();
        wr(AXI_OFF_HIGH, 32'h0000_1000);
        wr(AXI_OFF_LOW, 32'h0000_0100);
        wr(AXI_OFF_CFG, 32'h0000_0210);
        conv(16'h2000);
        st("hi set", 4'hd, 1'b0);
        conv(16'h0800);
        st("no fault", 4'hd, 1'b0);
        rd(AXI_OFF_CFG, rdat);
        st("cfg read", 4'h0, 1'b1);
        conv(16'h0010);
        st("lo set", 4'hb, 1'b0);
        wr(AXI_OFF_ALERT, 32'h0);
        st("alert", 4'h3, 1'b1);
        wr(AXI_OFF_CFG, 32'h0000_0010);
        st("shutdown", 4'h3, 1'b1);
        wr(AXI_OFF_CFG, 32'h0000_0211);
        st("run write", 4'h2, 1'b1);
        rd(AXI_OFF_CFG, rdat);
        conv(16'h2000);
        conv(16'h0010);
        conv(16'h2000);
        st("count 2 broken", 4'h1, 1'b1);
        conv(16'h2000);
        st("count 2 met", 4'hd, 1'b0);
        rd(AXI_OFF_CFG, rdat);
        $display("t_latched done");
    endtask

    task automatic t_transparent();
        wr(AXI_OFF_CFG, 32'h0000_0200);
        conv(16'h2000);
        st("tr hi", 4'hd, 1'b0);
        rd(AXI_OFF_CFG, rdat);
        st("tr read", 4'hc, 1'b0);
        wr(AXI_OFF_ALERT, 32'h0);
        st("tr alert", 4'hc, 1'b0);
        wr(AXI_OFF_CFG, 32'h0000_0208);
        st("pol high", 4'hc, 1'b1);
        conv(16'h0010);
        st("tr lo", 4'h3, 1'b0);
        $display("t_transparent done");
    endtask

    task automatic t_eoc();
        wr(AXI_OFF_HIGH, 32'h0000_ffff);
        wr(AXI_OFF_LOW, 32'h0000_c000);
        wr(AXI_OFF_CFG, 32'h0000_0210);
        rd(AXI_OFF_CFG, rdat);
        conv(16'hd000);
        st("eoc conv", 4'h9, 1'b0);
        wr(AXI_OFF_ALERT, 32'h0);
        st("eoc alert", 4'h1, 1'b1);
        conv(16'hd000);
        rd(AXI_OFF_CFG, rdat);
        st("eoc read", 4'h0, 1'b1);
        conv(16'hd000);
        wr(AXI_OFF_CFG, 32'h0000_0210);
        st("eoc write", 4'h0, 1'b1);
        conv(16'hd000);
        wr(AXI_OFF_LOW, 32'h0000_0000);
        wr(AXI_OFF_CFG, 32'h0000_0200);
        st("eoc leave", 4'h0, 1'b1);
        wr(AXI_OFF_CFG, 32'h0000_0210);
        $display("t_eoc done");
    endtask

    // Byte strobes, fault count of eight and a refused address beyond the map
    task automatic t_bus();
        i_wstrb <= 4'h1;
        wr(AXI_OFF_HIGH, 32'h0000_3355);
        i_wstrb <= 4'hf;
        rd(AXI_OFF_HIGH, rdat);
        chk("strobe", 32'h0000_ff55, rdat);
        wr(AXI_OFF_HIGH, 32'h0000_1000);
        wr(AXI_OFF_CFG, 32'h0000_0213);
        rd(AXI_OFF_CFG, rdat);
        repeat (7) conv(16'h2000);
        st("count 8 short", 4'h1, 1'b1);
        conv(16'h2000);
        st("count 8 met", 4'hd, 1'b0);
        rd(32'h0000_0100, rdat);
        chk("far read", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
        st("far read kept", 4'hd, 1'b0);
        $display("t_bus done");
    endtask

    initial
    begin
        {i_clk, i_reset, i_conv_done, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 8'h40;
        {i_result, i_awaddr, i_wdata, i_araddr} = '0;
        i_wstrb = 4'hf;
        n_errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_latched();
        t_transparent();
        t_eoc();
        t_bus();
        close_out();
    end
endmodule

// File: lti_top.sv
// Threshold comparison, flag and interrupt pin logic with AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// R1: Latched, high fault count met: flag high, interrupt active, ready set.
// R2: Latched, low fault count met: flag low, interrupt active, ready set.
// R3: Any finished conversion sets ready; flags and interrupt otherwise hold outside EOC.
// R4: Latched flags hold until a config read, which clears both flags and the interrupt.
// R5: A config read clears conversion ready afterwards, unless a conversion finishes in the same cycle.
// R6: Config write selecting shutdown changes no reporting state, except that writing latch 0 while latched outside EOC drops the interrupt.
// R7: Non-shutdown config write clears ready; flags kept, interrupt kept in comparison unless latch 0 is written while latched.
// R8: Latched alert response drops interrupt, keeps flags and ready.
// R9: Transparent, high count met: interrupt active, flag high 1, flag low 0.
// R10: Transparent, low count met: flag low 1, flag high 0; interrupt inactive outside EOC.
// R11: Transparent mode outside EOC: config accesses never touch interrupt or flags.
// R12: Transparent mode ignores alert response completely.
// R13: Config bit 4 selects latched when 1, transparent when 0.
// R14: Low limit top exponent bits 11b enter end-of-conversion mode.
// R15: EOC mode: every conversion activates interrupt and sets ready.
// R16: EOC interrupt cleared by config read, non-shutdown write, or alert when latched.
// R17: Pin driven low when active with polarity 0, or inactive with 1.
// R18: Host leaving EOC in latched mode writes latch 0 to clear interrupt.
// R19: Host keeps high limit above low limit.
// R20: Separate high and low consecutive counters, each reset when unmet.
module lti_top
(
    input  wire logic                         i_clk,
    input  wire logic                         i_reset,
    input  wire logic                         i_conv_done,
    input  wire logic [lti_pkg::RESULT_W-1:0] i_result,
    output logic                              o_int_oe,
    output logic                              o_int_out,
    input  wire logic [31:0]                  i_awaddr,
    input  wire logic                         i_awvalid,
    output logic                              o_awready,
    input  wire logic [31:0]                  i_wdata,
    input  wire logic [3:0]                   i_wstrb,
    input  wire logic                         i_wvalid,
    output logic                              o_wready,
    output logic [1:0]                        o_bresp,
    output logic                              o_bvalid,
    input  wire logic                         i_bready,
    input  wire logic [31:0]                  i_araddr,
    input  wire logic                         i_arvalid,
    output logic                              o_arready,
    output logic [31:0]                       o_rdata,
    output logic [1:0]                        o_rresp,
    output logic                              o_rvalid,
    input  wire logic                         i_rready
);
    import lti_pkg::*;

    logic [CFG_W-1:0]     cfg_q;
    logic [RESULT_W-1:0]  high_q;
    logic [RESULT_W-1:0]  low_q;
    logic                 flag_high_q;
    logic                 flag_low_q;
    logic                 conv_rdy_q;
    logic                 int_act_q;
    logic [EVT_CNT_W-1:0] hi_cnt_q;
    logic [EVT_CNT_W-1:0] lo_cnt_q;
    logic                 aw_got_q;
    logic                 w_got_q;
    logic [31:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    lti_wr_state_t        wr_state_q;

    // Fault count field 0..3 maps to 1, 2, 4, 8 consecutive events
    function automatic logic [EVT_CNT_W:0] fault_need(input logic [FAULT_CNT_W-1:0] fc);
        logic [EVT_CNT_W:0] n;
        n = '0;
        case (fc)
            2'h0: n = 4'h1;
            2'h1: n = 4'h2;
            2'h2: n = 4'h4;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    // Merges 16-bit register with byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic                   latched;
    logic                   eoc_mode;
    logic                   polarity;
    logic [EVT_CNT_W:0]     need;
    logic                   above;
    logic                   below;
    logic                   hi_met;
    logic                   lo_met;
    logic                   conv;
    logic                   cfg_rd;
    logic                   cfg_wr;
    logic                   cfg_wr_run;
    logic                   alert_ack;
    logic                   wr_fire;
    logic [15:0]            new_cfg;

    assign latched    = cfg_q[CFG_LATCH_BIT];                      // [R13]
    assign eoc_mode   = low_q[LOW_EXP_TOP_HI:LOW_EXP_TOP_LO] == EXP_TOP_EOC; // [R14]
    assign polarity   = cfg_q[CFG_POL_BIT];
    assign need       = fault_need(cfg_q[CFG_FC_LSB +: FAULT_CNT_W]);
    assign above      = i_result > high_q;
    assign below      = i_result < low_q;
    assign conv       = i_conv_done;
    assign hi_met     = conv && above && ({1'b0, hi_cnt_q} + 4'h1 >= need);
    assign lo_met     = conv && below && ({1'b0, lo_cnt_q} + 4'h1 >= need);
    assign wr_fire    = (wr_state_q == LTI_W_IDLE) && aw_got_q && w_got_q;
    assign new_cfg    = merge16(cfg_q, wdata_q, wstrb_q);
    // Refused addresses above the map must not alias onto the side effects
    assign cfg_wr     = wr_fire && awaddr_q[31:8] == '0 && awaddr_q[7:2] == AXI_OFF_CFG[7:2];
    assign cfg_wr_run = cfg_wr && new_cfg[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN; // [R6]
    assign alert_ack  = wr_fire && awaddr_q[31:8] == '0 && awaddr_q[7:2] == AXI_OFF_ALERT[7:2] && latched; // [R12]
    assign cfg_rd     = i_arvalid && o_arready && i_araddr[31:8] == '0 && i_araddr[7:2] == AXI_OFF_CFG[7:2];

    // Consecutive counters saturate one below eight to stay in width
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            hi_cnt_q <= '0;
            lo_cnt_q <= '0;
        end
        else if (conv)
        begin
            hi_cnt_q <= !above ? '0 : (&hi_cnt_q ? hi_cnt_q : hi_cnt_q + 3'h1); // [R20]
            lo_cnt_q <= !below ? '0 : (&lo_cnt_q ? lo_cnt_q : lo_cnt_q + 3'h1); // [R20]
        end
    end

    // Flags: set wins over a read clear in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            flag_high_q <= 1'b0;
            flag_low_q  <= 1'b0;
        end
        else if (latched)
        begin
            if (cfg_rd)
            begin
                flag_high_q <= 1'b0;                               // [R4]
                flag_low_q  <= 1'b0;                               // [R4]
            end
            if (hi_met)
                flag_high_q <= 1'b1;                               // [R1]
            if (lo_met)
                flag_low_q <= 1'b1;                                // [R2]
        end
        else if (hi_met)
        begin
            flag_high_q <= 1'b1;                                   // [R9]
            flag_low_q  <= 1'b0;
        end
        else if (lo_met)
        begin
            flag_high_q <= 1'b0;                                   // [R10]
            flag_low_q  <= 1'b1;
        end
    end

    // Interrupt state; outside EOC a latch-bit write to 0 drops a latched interrupt
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            int_act_q <= 1'b0;
        else if (latched || eoc_mode)
        begin
            if (cfg_rd || alert_ack || (eoc_mode && cfg_wr_run))
                int_act_q <= 1'b0;                                 // [R4] [R8] [R16]
            else if (cfg_wr && latched && !new_cfg[CFG_LATCH_BIT] && !eoc_mode)
                int_act_q <= 1'b0;                                 // [R18]
            if (hi_met || lo_met || (eoc_mode && conv))
                int_act_q <= 1'b1;                                 // [R1] [R2] [R15]
        end
        else if (hi_met)
            int_act_q <= 1'b1;                                     // [R9]
        else if (lo_met)
            int_act_q <= 1'b0;                                     // [R10] [R11]
    end

    // Conversion ready
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            conv_rdy_q <= 1'b0;
        else if (conv)
            conv_rdy_q <= 1'b1;                                    // [R3] [R15]
        else if (cfg_rd || cfg_wr_run)
            conv_rdy_q <= 1'b0;                                    // [R5] [R7]
    end

    // Open-drain pin, oe high pulls low
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_int_oe  <= 1'b0;
            o_int_out <= 1'b0;
        end
        else
        begin
            o_int_oe  <= int_act_q ^ polarity;                     // [R17]
            o_int_out <= 1'b0;
        end
    end

    // Write channel capture; either order accepted
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            aw_got_q   <= 1'b0;
            w_got_q    <= 1'b0;
            awaddr_q   <= '0;
            wdata_q    <= '0;
            wstrb_q    <= '0;
            o_awready  <= 1'b0;
            o_wready   <= 1'b0;
            o_bvalid   <= 1'b0;
            o_bresp    <= RESP_OKAY;
            wr_state_q <= LTI_W_IDLE;
        end
        else
        begin
            o_awready <= !aw_got_q && !(i_awvalid && o_awready) && wr_state_q == LTI_W_IDLE;
            o_wready  <= !w_got_q && !(i_wvalid && o_wready) && wr_state_q == LTI_W_IDLE;
            if (i_awvalid && o_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            case (wr_state_q)
                LTI_W_IDLE:
                    if (wr_fire)
                    begin
                        aw_got_q   <= 1'b0;
                        w_got_q    <= 1'b0;
                        o_bvalid   <= 1'b1;
                        o_bresp    <= (awaddr_q[7:2] <= AXI_OFF_ALERT[7:2] && awaddr_q[31:8] == '0
                                       && awaddr_q[7:2] != AXI_OFF_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
                        wr_state_q <= LTI_W_RESP;
                    end
                LTI_W_RESP:
                    if (i_bready)
                    begin
                        o_bvalid   <= 1'b0;
                        wr_state_q <= LTI_W_IDLE;
                    end
                default:
                    wr_state_q <= LTI_W_IDLE;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cfg_q  <= CFG_RESET;
            high_q <= HIGH_RESET;
            low_q  <= LOW_RESET;
        end
        else if (wr_fire && awaddr_q[31:8] == '0)
        begin
            if (awaddr_q[7:2] == AXI_OFF_CFG[7:2])
                cfg_q <= new_cfg;
            if (awaddr_q[7:2] == AXI_OFF_HIGH[7:2])
                high_q <= merge16(high_q, wdata_q, wstrb_q);
            if (awaddr_q[7:2] == AXI_OFF_LOW[7:2])
                low_q <= merge16(low_q, wdata_q, wstrb_q);
        end
    end

    // Read channel; config read returns cfg_q only, not the status fields that it clears
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end
        else
        begin
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready)
            begin
                o_rvalid <= 1'b1;
                o_rresp  <= RESP_OKAY;
                o_rdata  <= '0;
                if (i_araddr[31:8] != '0)
                    o_rresp <= RESP_SLVERR;
                else if (i_araddr[7:2] == AXI_OFF_CFG[7:2])
                    o_rdata <= {16'h0000, cfg_q};
                else if (i_araddr[7:2] == AXI_OFF_HIGH[7:2])
                    o_rdata <= {16'h0000, high_q};
                else if (i_araddr[7:2] == AXI_OFF_LOW[7:2])
                    o_rdata <= {16'h0000, low_q};
                else if (i_araddr[7:2] == AXI_OFF_STATUS[7:2])
                    o_rdata <= {28'h0000000, int_act_q, flag_high_q, flag_low_q, conv_rdy_q};
                else if (i_araddr[7:2] != AXI_OFF_ALERT[7:2])
                    o_rresp <= RESP_SLVERR;
            end
            else if (o_rvalid && i_rready)
                o_rvalid <= 1'b0;
        end
    end
endmodule
